// ===== isrp_pkg.sv
// Shared constants and types for the two-wire register port
package isrp_pkg;

    localparam int DATA_W = 8;
    localparam int REG_AW = 8;
    localparam int ADDR_LO_W = 2;
    localparam logic [4:0] ADDR_HI = 5'h0a;
    localparam logic [7:0] FIFO_ADDR_DEF = 8'h05;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // Spike suppression on the link inputs
    localparam int SPIKE_NS = 50;
    localparam int LINK_PERIOD_NS = 30;
    localparam int SPIKE_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

    // Host reference clock, kHz, and bit rate limits, kbit/s
    localparam int REF_CLK_KHZ = 250000;
    localparam int FAST_KBPS = 400;
    localparam int FASTPLUS_KBPS = 1000;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_PTR,
        PH_WDATA,
        PH_RDATA
    } isrp_phase_e;

    typedef enum logic [1:0] {
        CMD_START,
        CMD_WRITE,
        CMD_READ,
        CMD_STOP
    } isrp_cmd_e;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_START,
        HS_BIT,
        HS_STOP
    } isrp_hstate_e;

endpackage

// ===== isrp_if.sv
// Two-wire link between host end and device end, with wired-AND SDA
`timescale 1ns/1ps
`default_nettype none
interface isrp_if;
    logic scl;
    logic hostSdaOut;
    logic hostSdaOeN;
    logic devSdaOut;
    logic devSdaOeN;
    logic sda;

    // Pull-up: the line is low only while some end drives a low
    assign sda = ((!hostSdaOeN && !hostSdaOut) ||
                  (!devSdaOeN && !devSdaOut)) ? 1'b0 : 1'b1;

    modport dev (
        input scl,
        input sda,
        output devSdaOut,
        output devSdaOeN
    );

    modport host (
        output scl,
        output hostSdaOut,
        output hostSdaOeN,
        input sda
    );
endinterface
`default_nettype wire

// ===== isrp_device.sv
// Device end: two-wire slave with register pointer and register access port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Slave only, standard, fast, fast-plus.
// - Never stretch SCL; follow every pulse.
// - Ignore general call; no bus reset.
// - No device identification query.
// - No SCL generation, no arbitration.
// - Master never uses high-speed mode.
// - Master rate at most 400k or 1M.
// - Glitch filter on SCL and SDA.
// - SDA changes only while SCL low.
// - SDA fall/rise at SCL high: START/STOP.
// - Master issues START/STOP; repeated START same.
// - MSB first, one acknowledge per byte.
// - Ninth pulse: sender releases, receiver pulls low.
// - Master nacks last read byte; release SDA.
// - Address 01010 plus two selectable bits.
// - Write: address W, pointer, data bytes.
// - FIFO pointer: all data goes to FIFO.
// - Read starts with pointer-only write.
// - Read returns pointed register first.
// - Pointer advances per read byte, not FIFO.
// - Read phase uses direction bit one.
module isrp_device
    import isrp_pkg::*;
#(
    parameter logic [REG_AW-1:0] FIFO_ADDR = FIFO_ADDR_DEF
)
(
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    // Low address bits from pins or configuration
    input wire logic [ADDR_LO_W-1:0] addrSel,
    // Register write port, ref_clk
    output logic regWrEn,
    output logic [REG_AW-1:0] regWrAddr,
    output logic [DATA_W-1:0] regWrData,
    // Register read port, ref_clk
    output logic regRdEn,
    output logic [REG_AW-1:0] regRdAddr,
    input wire logic [DATA_W-1:0] regRdData,
    // Link
    isrp_if.dev bus
);

    localparam int FILT_W = $clog2(SPIKE_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain: reset, pin synchronisers, spike filter

    logic [1:0] rstS_q;
    logic linkRst;
    logic [1:0] sclS_q;
    logic [1:0] sdaS_q;
    logic [ADDR_LO_W-1:0] selS0_q;
    logic [ADDR_LO_W-1:0] selS1_q;
    logic [1:0] pinRaw;
    logic [1:0] pinF;
    logic sclP_q;
    logic sdaP_q;

    always_ff @(posedge linkClk)
    begin
        rstS_q <= {rstS_q[0], sys_rst};
        sclS_q <= {sclS_q[0], bus.scl};
        sdaS_q <= {sdaS_q[0], bus.sda};
        selS0_q <= addrSel;
        selS1_q <= selS0_q;
    end

    assign linkRst = rstS_q[1];
    assign pinRaw = {sclS_q[1], sdaS_q[1]};

    // A change is taken only after it has held for the spike time
    for (genvar g = 0; g < 2; g++)
    begin : gFilt
        logic [FILT_W-1:0] cnt_q;
        logic f_q;
        always_ff @(posedge linkClk)
        begin
            if (linkRst)
            begin
                cnt_q <= '0;
                f_q <= 1'b1;
            end
            else if (pinRaw[g] == f_q)
                cnt_q <= '0;
            else if (cnt_q == FILT_W'(SPIKE_CYC - 1))
            begin
                f_q <= pinRaw[g];
                cnt_q <= '0;
            end
            else
                cnt_q <= cnt_q + 1'b1;
        end
        assign pinF[g] = f_q;
    end

    logic sclF;
    logic sdaF;
    assign sclF = pinF[1];
    assign sdaF = pinF[0];

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
        end
        else
        begin
            sclP_q <= sclF;
            sdaP_q <= sdaF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus engine

    isrp_phase_e ph_q;
    isrp_phase_e nxt_q;
    isrp_phase_e phNow;
    logic [3:0] bit_q;
    logic [DATA_W-1:0] rx_q;
    logic [DATA_W-1:0] tx_q;
    logic [DATA_W-1:0] txSrc;
    logic [DATA_W-1:0] rdHold_q;
    logic [REG_AW-1:0] ptr_q;
    logic sdaLow_q;
    logic startEv;
    logic stopEv;
    logic riseEv;
    logic fallEv;
    logic decideEv;
    logic addrHit;
    logic mAckEv;

    assign startEv = sclF && sclP_q && sdaP_q && !sdaF;
    assign stopEv = sclF && sclP_q && !sdaP_q && sdaF;
    assign riseEv = sclF && !sclP_q && ph_q != PH_IDLE;
    assign fallEv = !sclF && sclP_q && ph_q != PH_IDLE;
    assign decideEv = fallEv && bit_q == BIT_LAST;
    // Fixed upper bits keep general call and ID query from ever matching
    assign addrHit = rx_q[7:1] == {ADDR_HI, selS1_q};
    assign mAckEv = riseEv && bit_q == BIT_ACK && ph_q == PH_RDATA && !sdaF;
    assign phNow = (bit_q == BIT_ACK && ph_q != PH_RDATA) ? nxt_q : ph_q;
    assign txSrc = (bit_q == BIT_ACK) ? rdHold_q : tx_q;

    // Only SDA is ever driven, and only on SCL falls
    always_ff @(posedge linkClk)
    begin
        if (linkRst || stopEv)
        begin
            ph_q <= PH_IDLE;
            bit_q <= '0;
            sdaLow_q <= 1'b0;
        end
        else if (startEv)
        begin
            ph_q <= PH_ADDR;
            // Parked one below bit 0: the SCL fall that closes START
            // wraps it to 0 instead of being counted as a data bit
            bit_q <= '1;
            sdaLow_q <= 1'b0;
        end
        else if (riseEv && bit_q == BIT_ACK && ph_q == PH_RDATA && sdaF)
            ph_q <= PH_IDLE;
        else if (decideEv)
        begin
            bit_q <= BIT_ACK;
            if (ph_q == PH_ADDR && !addrHit)
                ph_q <= PH_IDLE;
            sdaLow_q <= ph_q != PH_RDATA &&
                        (ph_q != PH_ADDR || addrHit);
        end
        else if (fallEv)
        begin
            bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
            ph_q <= phNow;
            sdaLow_q <= phNow == PH_RDATA && !txSrc[7];
        end
    end

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            rx_q <= '0;
            tx_q <= '0;
            nxt_q <= PH_IDLE;
        end
        else
        begin
            if (riseEv && bit_q != BIT_ACK)
                rx_q <= {rx_q[6:0], sdaF};
            if (fallEv && bit_q != BIT_LAST)
                tx_q <= {txSrc[6:0], 1'b0};
            if (decideEv)
            begin
                if (ph_q == PH_ADDR)
                    nxt_q <= rx_q[0] ? PH_RDATA : PH_PTR;
                else
                    nxt_q <= PH_WDATA;
            end
        end
    end

    // Pointer: set by the first byte, then steps unless it names the FIFO
    always_ff @(posedge linkClk)
    begin
        if (linkRst)
            ptr_q <= '0;
        else if (decideEv && ph_q == PH_PTR)
            ptr_q <= rx_q;
        else if (decideEv && (ph_q == PH_WDATA || ph_q == PH_RDATA)
                 && ptr_q != FIFO_ADDR)
            ptr_q <= ptr_q + 1'b1;
    end

    assign bus.devSdaOut = 1'b0;
    assign bus.devSdaOeN = !sdaLow_q;

    ////////////////////////////////////////////////////////////////////////
    // Crossing to ref_clk: toggles with words held stable behind them

    logic wrTog_q;
    logic rdTog_q;
    logic [REG_AW-1:0] wrAddr_q;
    logic [DATA_W-1:0] wrData_q;
    logic [2:0] ackS_q;

    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            wrTog_q <= 1'b0;
            rdTog_q <= 1'b0;
            wrAddr_q <= '0;
            wrData_q <= '0;
        end
        else
        begin
            if (decideEv && ph_q == PH_WDATA)
            begin
                wrAddr_q <= ptr_q;
                wrData_q <= rx_q;
                wrTog_q <= !wrTog_q;
            end
            if ((decideEv && ph_q == PH_ADDR && addrHit && rx_q[0]) || mAckEv)
                rdTog_q <= !rdTog_q;
        end
    end

    logic [DATA_W-1:0] rdData_q;
    logic ackTog_q;

    // The fetch has the SCL high phase of the master acknowledge to land; slow user logic is not
    // waited for
    always_ff @(posedge linkClk)
    begin
        if (linkRst)
        begin
            ackS_q <= '0;
            rdHold_q <= '0;
        end
        else
        begin
            ackS_q <= {ackS_q[1:0], ackTog_q};
            if (ackS_q[2] != ackS_q[1])
                rdHold_q <= rdData_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ref_clk domain: register port

    logic [2:0] wrS_q;
    logic [2:0] rdS_q;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wrS_q <= '0;
            rdS_q <= '0;
            regWrEn <= 1'b0;
            regWrAddr <= '0;
            regWrData <= '0;
        end
        else
        begin
            wrS_q <= {wrS_q[1:0], wrTog_q};
            rdS_q <= {rdS_q[1:0], rdTog_q};
            regWrEn <= wrS_q[2] != wrS_q[1];
            if (wrS_q[2] != wrS_q[1])
            begin
                regWrAddr <= wrAddr_q;
                regWrData <= wrData_q;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            regRdEn <= 1'b0;
            regRdAddr <= '0;
            rdData_q <= '0;
            ackTog_q <= 1'b0;
        end
        else
        begin
            regRdEn <= rdS_q[2] != rdS_q[1];
            if (rdS_q[2] != rdS_q[1])
                regRdAddr <= ptr_q;
            if (regRdEn)
            begin
                rdData_q <= regRdData;
                ackTog_q <= !ackTog_q;
            end
        end
    end

endmodule
`default_nettype wire

// ===== isrp_host.sv
// Host end: bus master driving SCL from ref_clk and issuing byte commands
`timescale 1ns/1ps
`default_nettype none
module isrp_host
    import isrp_pkg::*;
#(
    parameter int SCL_KHZ = FAST_KBPS
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire isrp_cmd_e cmdKind,
    input wire logic [DATA_W-1:0] cmdData,
    input wire logic cmdAck,
    // Response
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    output logic rspAckRx,
    // Link
    isrp_if.host bus
);

    // Round the quarter period up so the rate never exceeds SCL_KHZ
    localparam int QTR_RAW = (REF_CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
    localparam int QTR_CYC = (QTR_RAW < 1) ? 1 : QTR_RAW;
    localparam int DIV_W = $clog2(QTR_CYC + 1);

    isrp_hstate_e st_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0] q_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    logic sclQ;
    logic sdaRel_q;
    logic [1:0] sdaS_q;
    logic tick;

    assign tick = div_q == DIV_W'(QTR_CYC - 1);
    assign cmdReady = st_q == HS_IDLE;
    assign bus.scl = sclQ;
    assign bus.hostSdaOut = 1'b0;
    assign bus.hostSdaOeN = sdaRel_q;

    always_ff @(posedge ref_clk)
    begin
        sdaS_q <= {sdaS_q[0], bus.sda};
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || st_q == HS_IDLE || tick)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    // Each bit is four quarters: set SDA, raise SCL, sample, drop SCL
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st_q <= HS_IDLE;
            q_q <= '0;
            bit_q <= '0;
            sh_q <= '1;
            sclQ <= 1'b1;
            sdaRel_q <= 1'b1;
            rspValid <= 1'b0;
            rspData <= '0;
            rspAckRx <= 1'b0;
        end
        else
        begin
            rspValid <= 1'b0;
            if (st_q == HS_IDLE)
            begin
                if (cmdValid)
                begin
                    q_q <= '0;
                    bit_q <= '0;
                    case (cmdKind)
                        CMD_START: st_q <= HS_START;
                        CMD_STOP: st_q <= HS_STOP;
                        CMD_WRITE:
                        begin
                            st_q <= HS_BIT;
                            sh_q <= {cmdData, 1'b1};
                        end
                        default:
                        begin
                            st_q <= HS_BIT;
                            sh_q <= {8'hff, !cmdAck};
                        end
                    endcase
                end
            end
            else if (tick)
            begin
                q_q <= q_q + 2'h1;
                case (st_q)
                    HS_START:
                    begin
                        // Repeated START uses the same path
                        case (q_q)
                            2'h0: sdaRel_q <= 1'b1;
                            2'h1: sclQ <= 1'b1;
                            2'h2: sdaRel_q <= 1'b0;
                            default:
                            begin
                                sclQ <= 1'b0;
                                st_q <= HS_IDLE;
                            end
                        endcase
                    end
                    HS_STOP:
                    begin
                        case (q_q)
                            2'h0: sdaRel_q <= 1'b0;
                            2'h1: sclQ <= 1'b1;
                            2'h2: sdaRel_q <= 1'b1;
                            default: st_q <= HS_IDLE;
                        endcase
                    end
                    default:
                    begin
                        case (q_q)
                            2'h0: sdaRel_q <= sh_q[8];
                            2'h1: sclQ <= 1'b1;
                            2'h2:
                            begin
                                if (bit_q == BIT_ACK)
                                    rspAckRx <= !sdaS_q[1];
                                else
                                    rspData <= {rspData[6:0], sdaS_q[1]};
                            end
                            default:
                            begin
                                sclQ <= 1'b0;
                                sh_q <= {sh_q[7:0], 1'b1};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == BIT_ACK)
                                begin
                                    st_q <= HS_IDLE;
                                    rspValid <= 1'b1;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ===== isrp_checker.sv
// Link protocol checker for the two-wire register port
`timescale 1ns/1ps
`default_nettype none
module isrp_checker
    import isrp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    input wire logic scl,
    input wire logic hostSdaOut,
    input wire logic hostSdaOeN,
    input wire logic devSdaOut,
    input wire logic devSdaOeN,
    input wire logic sda
);
////////////////////////////////////////////////////////////////////////////////
logic sclQ;
logic sdaQ;
logic isAddr_q;
logic rdMode_q;
logic matched_q;
logic [3:0] bitCnt_q;
logic [7:0] shift_q;
logic sclRise;
logic startEv;
logic ackBit;

assign sclRise = scl && !sclQ;
assign startEv = scl && sclQ && sdaQ && !sda;
assign ackBit = sclRise && bitCnt_q == BIT_ACK;

// Idle levels at reset so no false edge is seen on release
always_ff @(posedge ref_clk)
begin
    sclQ <= sys_rst ? 1'b1 : scl;
    sdaQ <= sys_rst ? 1'b1 : sda;
end

always_ff @(posedge ref_clk)
begin
    if (sys_rst || startEv)
        bitCnt_q <= 4'h0;
    else if (ackBit)
        bitCnt_q <= 4'h0;
    else if (sclRise)
        bitCnt_q <= bitCnt_q + 4'h1;
    if (sclRise && !ackBit)
        shift_q <= {shift_q[6:0], sda};
end

always_ff @(posedge ref_clk)
begin
    if (sys_rst)
    begin
        isAddr_q <= 1'b0;
        rdMode_q <= 1'b0;
        matched_q <= 1'b0;
    end
    else if (startEv)
        isAddr_q <= 1'b1;
    else if (ackBit && isAddr_q)
    begin
        isAddr_q <= 1'b0;
        rdMode_q <= shift_q[0];
        matched_q <= !sda;
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge ref_clk); endclocking
default disable iff (sys_rst);

property p_openDrain; devSdaOut == 1'b0; endproperty
property p_devHold; !$stable(devSdaOeN) |-> !scl && !$past(scl); endproperty
property p_start; startEv |-> devSdaOeN; endproperty
property p_foreign;
    ackBit && isAddr_q && shift_q[7:3] != ADDR_HI |-> sda;
endproperty
property p_genCall; ackBit && isAddr_q && shift_q[7:1] == 7'h00 |-> sda;
endproperty
property p_bitStable; sclRise && !ackBit |-> $stable(sda) [*8]; endproperty
property p_ackHold; ackBit && !sda |-> !sda [*8]; endproperty
property p_writeAck;
    ackBit && !isAddr_q && !rdMode_q && matched_q |-> !sda;
endproperty
property p_rdAckFree; ackBit && !isAddr_q && rdMode_q |-> devSdaOeN;
endproperty
// After a master nack the device must not drive the next bit
property p_nackRel;
    ackBit && !isAddr_q && rdMode_q && sda |-> ##200 devSdaOeN;
endproperty

a_openDrain: assert property (p_openDrain)
    else $error("device drove SDA high");
a_devHold: assert property (p_devHold)
    else $error("device changed SDA while SCL high");
a_start: assert property (p_start)
    else $error("device holds SDA at START");
a_foreign: assert property (p_foreign)
    else $error("foreign address acknowledged");
a_genCall: assert property (p_genCall)
    else $error("general call acknowledged");
a_bitStable: assert property (p_bitStable)
    else $error("data bit changed in SCL high");
a_ackHold: assert property (p_ackHold)
    else $error("acknowledge not stable");
a_writeAck: assert property (p_writeAck)
    else $error("write byte not acknowledged");
a_rdAckFree: assert property (p_rdAckFree)
    else $error("device drove master acknowledge");
a_nackRel: assert property (p_nackRel)
    else $error("SDA not released after nack");

c_write: cover property (ackBit && matched_q && !rdMode_q && !isAddr_q);
c_readNack: cover property (ackBit && rdMode_q && !isAddr_q && sda);
c_foreign: cover property (ackBit && isAddr_q && sda);
endmodule
`default_nettype wire

// ===== i2c_slave_register_port_tb.sv
// Self-checking bench: host end driving device end over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(16'(g), 16'(e));
module i2c_slave_register_port_tb;
import isrp_pkg::*;
// Fast-plus SCL keeps the run short while leaving the device ample margin
localparam int SCL_KHZ = 1000;
logic ref_clk = 1'b0;
logic linkClk = 1'b0;
logic sys_rst = 1'b1;
logic cmdValid = 1'b0;
isrp_cmd_e cmdKind = CMD_START;
logic [7:0] cmdData = 8'h00;
logic cmdAck = 1'b0;
logic [1:0] addrSel = 2'h2;
logic cmdReady, rspValid, rspAckRx, regWrEn, regRdEn;
logic [7:0] rspData, regWrAddr, regWrData, regRdAddr, regRdData;
logic [7:0] mem [256];
logic [7:0] logA [$];
logic [7:0] logD [$];
logic [8:0] wireBits = 9'h000;
int wrIdx = 0;
int miscompares = 0;
int tests_run = 0;
////////////////////////////////////////////////////////////////////////////////
initial forever #2 ref_clk = ~ref_clk;
initial
begin
    #7;
    forever #15 linkClk = ~linkClk;
end

isrp_if isrp_if_i ();
isrp_device isrp_device_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .linkClk(linkClk), .addrSel(addrSel), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .bus(isrp_if_i.dev));
isrp_host #(.SCL_KHZ(SCL_KHZ)) isrp_host_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdKind(cmdKind), .cmdData(cmdData), .cmdAck(cmdAck),
    .rspValid(rspValid), .rspData(rspData), .rspAckRx(rspAckRx),
    .bus(isrp_if_i.host));
isrp_checker isrp_checker_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .scl(isrp_if_i.scl),
    .hostSdaOut(isrp_if_i.hostSdaOut), .hostSdaOeN(isrp_if_i.hostSdaOeN),
    .devSdaOut(isrp_if_i.devSdaOut), .devSdaOeN(isrp_if_i.devSdaOeN),
    .sda(isrp_if_i.sda));

// Register file stands in for the user side of the device
assign regRdData = mem[regRdAddr];
always @(posedge ref_clk)
begin
    if (regWrEn === 1'b1)
    begin
        mem[regWrAddr] <= regWrData;
        logA.push_back(regWrAddr);
        logD.push_back(regWrData);
    end
end
always @(posedge isrp_if_i.scl) wireBits <= {wireBits[7:0], isrp_if_i.sda};
////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
        miscompares++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
endtask

task automatic results();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask

task automatic cmd(input isrp_cmd_e k, input logic [7:0] d, input logic a);
    int n;
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdData <= d;
    cmdAck <= a;
    @(negedge ref_clk);
    for (n = 0; n < 3000 && cmdReady !== 1'b1; n++)
        @(negedge ref_clk);
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    for (n = 0; n < 3000; n++)
    begin
        @(negedge ref_clk);
        if (k == CMD_START || k == CMD_STOP ? cmdReady === 1'b1
                : rspValid === 1'b1)
            break;
    end
    // A command that never completes is a failure, not a silent skip
    if (n == 3000)
    begin
        miscompares++;
        results();
    end
endtask

task automatic wrByte(input logic [7:0] d, input logic expAck);
    cmd(CMD_WRITE, d, 1'b0);
    `CHK(rspAckRx, expAck)
    `CHK(wireBits, {d, !expAck})
endtask

task automatic rdByte(input logic a, input logic [7:0] e);
    cmd(CMD_READ, 8'h00, a);
    `CHK(rspData, e)
    `CHK(wireBits, {e, !a})
endtask

task automatic expWr(input logic [7:0] a, input logic [7:0] d);
    `CHK({logA[wrIdx], logD[wrIdx]}, {a, d})
    wrIdx++;
endtask

task automatic frameHead(input logic [7:0] ptr, input logic rd);
    cmd(CMD_START, 8'h00, 1'b0);
    wrByte({ADDR_HI, addrSel, 1'b0}, 1'b1);
    wrByte(ptr, 1'b1);
    if (rd)
    begin
        cmd(CMD_START, 8'h00, 1'b0);
        wrByte({ADDR_HI, addrSel, 1'b1}, 1'b1);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    #380000;
    miscompares++;
    results();
end

initial
begin
    for (int i = 0; i < 256; i++)
        mem[i] = 8'(i) ^ 8'h5a;
    // Held over six link cycles so the device side sees reset too
    repeat (6) @(posedge linkClk);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge linkClk);
    `CHK({isrp_if_i.scl, isrp_if_i.sda}, 2'b11)
    frameHead(8'h10, 1'b0);
    wrByte(8'ha1, 1'b1);
    wrByte(8'ha2, 1'b1);
    wrByte(8'ha3, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    expWr(8'h10, 8'ha1);
    expWr(8'h11, 8'ha2);
    expWr(8'h12, 8'ha3);
    `CHK({isrp_if_i.scl, isrp_if_i.sda}, 2'b11)
    $display("test burst_write done");
    frameHead(FIFO_ADDR_DEF, 1'b0);
    wrByte(8'hb1, 1'b1);
    wrByte(8'hb2, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    expWr(FIFO_ADDR_DEF, 8'hb1);
    expWr(FIFO_ADDR_DEF, 8'hb2);
    $display("test fifo_write done");
    frameHead(8'h10, 1'b1);
    rdByte(1'b1, 8'ha1);
    rdByte(1'b1, 8'ha2);
    rdByte(1'b0, 8'ha3);
    cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test burst_read done");
    frameHead(FIFO_ADDR_DEF, 1'b1);
    rdByte(1'b1, 8'hb2);
    rdByte(1'b0, 8'hb2);
    cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test fifo_read done");
    // Foreign address, then general call: both ignored to the next START
    for (int i = 0; i < 2; i++)
    begin
        cmd(CMD_START, 8'h00, 1'b0);
        wrByte(i == 0 ? {ADDR_HI, ~addrSel, 1'b0} : 8'h00, 1'b0);
        wrByte(8'h33, 1'b0);
        cmd(CMD_STOP, 8'h00, 1'b0);
    end
    `CHK(logA.size(), wrIdx)
    $display("test foreign_address done");
    @(posedge ref_clk);
    addrSel <= 2'h1;
    frameHead(8'hff, 1'b0);
    wrByte(8'hc1, 1'b1);
    wrByte(8'hc2, 1'b1);
    cmd(CMD_STOP, 8'h00, 1'b0);
    expWr(8'hff, 8'hc1);
    expWr(8'h00, 8'hc2);
    `CHK(logA.size(), wrIdx)
    $display("test pin_address_wrap done");
    results();
end
endmodule
`default_nettype wire
